// ---- rtl/ati_pkg.sv ----
package ati_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_ODD_FIRST   = 8'h67;
   localparam logic [7:0] IDX_ODD_SECOND  = 8'h68;
   localparam logic [7:0] IDX_EVEN_FIRST  = 8'h69;
   localparam logic [7:0] IDX_EVEN_SECOND = 8'h6A;
   // Field layout
   localparam int         ENABLE_BIT      = 15;
   localparam int         ARG_W           = 12;
   localparam int         REG_W           = 16;
   // Reset values
   localparam logic [11:0] ARG_RST        = 12'h000;
   localparam logic        ENABLE_RST     = 1'b0;
   // Scan type and oversample ratio codes
   localparam logic [2:0] SCAN_CALIBRATE  = 3'h3;
   localparam logic [2:0] OVS_SINGLE      = 3'h0;
   // Unity gain and zero offset for the correction path
   localparam logic [15:0] GAIN_UNITY     = 16'h8000;
   localparam logic [15:0] OFFSET_ZERO    = 16'h0000;
   // Answer value for unmapped reads
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
   // Bus timing: answer one cycle after the request is seen
   localparam int         BUS_WAIT_CYC    = 1;
endpackage

// ---- rtl/ati_cfg_if.sv ----
`timescale 1ns/10ps
// Argument set handed from the register file to the selection logic
interface ati_cfg_if;
   logic        enable;                 // Test mode bit
   logic [11:0] arg_odd_first;          // Odd sample, first conversion
   logic [11:0] arg_odd_second;         // Odd sample, second conversion
   logic [11:0] arg_even_first;         // Even sample, first conversion
   logic [11:0] arg_even_second;        // Even sample, second conversion
   modport regs (output enable, output arg_odd_first, output arg_odd_second,
                 output arg_even_first, output arg_even_second);
   modport sel  (input enable, input arg_odd_first, input arg_odd_second,
                 input arg_even_first, input arg_even_second);
endinterface

// ---- rtl/ati_regs.sv ----
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module ati_regs (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Register contents
   ati_cfg_if.regs          cfg
);
   typedef struct packed {
      logic        en;
      logic [11:0] a1a;
      logic [11:0] a1b;
      logic [11:0] a2a;
      logic [11:0] a2b;
      logic        busy;
      logic [31:0] rdata;
   } ati_rstate_t;

   ati_rstate_t s_q;                    // Registered state
   ati_rstate_t s_d;                    // Next state

   // Word index from byte address
   function automatic logic [7:0] word_idx(input logic [9:0] a);
      return a[9:2];
   endfunction

   // Merge byte lanes of a 16-bit register image
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) r[7:0]  = wd[7:0];
      if (be[1]) r[15:8] = wd[15:8];
      return r;
   endfunction

   // Bus decode, write and read mux
   always_comb begin
      logic        go;
      logic        wr;
      logic [15:0] img;
      s_d  = s_q;
      go   = (avs_read_i | avs_write_i) & ~s_q.busy;
      // A write lands only at the edge that sees waitrequest low
      wr   = avs_write_i & s_q.busy;
      img  = 16'h0000;
      // First cycle stalls, second cycle completes
      s_d.busy = go;
      // Read data latched on the stall cycle so it stands at the answer
      if (go) begin
         s_d.rdata = ati_pkg::UNMAPPED_DATA;
      end
      if (go | wr) begin
         unique case (word_idx(avs_address_i))
            ati_pkg::IDX_ODD_FIRST: begin
               img = merge({s_q.en, 3'h0, s_q.a1a}, avs_writedata_i,
                           avs_byteenable_i);
               if (wr) begin
                  s_d.en  = img[ati_pkg::ENABLE_BIT];         // RULE1
                  s_d.a1a = img[11:0];                        // RULE13
               end
               if (go) begin
                  s_d.rdata = {16'h0000, s_q.en, 3'h0, s_q.a1a};  // RULE13
               end
            end
            ati_pkg::IDX_ODD_SECOND: begin
               img = merge({4'h0, s_q.a1b}, avs_writedata_i,
                           avs_byteenable_i);
               if (wr) s_d.a1b = img[11:0];                   // RULE13
               if (go) s_d.rdata = {20'h00000, s_q.a1b};
            end
            ati_pkg::IDX_EVEN_FIRST: begin
               img = merge({4'h0, s_q.a2a}, avs_writedata_i,
                           avs_byteenable_i);
               if (wr) s_d.a2a = img[11:0];                   // RULE13
               if (go) s_d.rdata = {20'h00000, s_q.a2a};
            end
            ati_pkg::IDX_EVEN_SECOND: begin
               img = merge({4'h0, s_q.a2b}, avs_writedata_i,
                           avs_byteenable_i);
               if (wr) s_d.a2b = img[11:0];                   // RULE13
               if (go) s_d.rdata = {20'h00000, s_q.a2b};
            end
            default: ;                  // Unmapped: reads zero, writes drop
         endcase
      end
   end

   // Register the state
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.en    <= ati_pkg::ENABLE_RST;                     // RULE1
         s_q.a1a   <= ati_pkg::ARG_RST;
         s_q.a1b   <= ati_pkg::ARG_RST;
         s_q.a2a   <= ati_pkg::ARG_RST;
         s_q.a2b   <= ati_pkg::ARG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Waitrequest is high unless answering this cycle
   assign avs_waitrequest_o   = ~s_q.busy;
   assign avs_readdata_o      = s_q.rdata;
   assign cfg.enable          = s_q.en;
   assign cfg.arg_odd_first   = s_q.a1a;
   assign cfg.arg_odd_second  = s_q.a1b;
   assign cfg.arg_even_first  = s_q.a2a;
   assign cfg.arg_even_second = s_q.a2b;
endmodule

// ---- rtl/ati_injector.sv ----
`timescale 1ns/10ps
// Operation
// (RULE1) Bit 15 enables test mode, reset clear
// (RULE2) Test mode replaces converter data with arguments
// (RULE3) Ordinary scans still run in test mode
// (RULE4) Test mode forces unity gain, zero offset
// (RULE5) Calibration scans always use real data
// (RULE6) Balancing scans always use real data
// (RULE7) Odd sample first conversion takes odd-first
// (RULE8) Odd sample second conversion takes odd-second
// (RULE9) Even sample first conversion takes even-first
// (RULE10) Even sample second conversion takes even-second
// (RULE11) Calibration scan only updates correction coefficients
// (RULE12) Oversample code zero means single acquisition
// (RULE13) Arguments read back; unused bits read zero
module ati_injector (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Scan context from the sequencer
   input  wire logic [2:0]  scan_type_select_i,
   input  wire logic [2:0]  oversample_ratio_i,
   input  wire logic        balance_scan_i,
   input  wire logic        sample_odd_i,
   input  wire logic        conv_second_i,
   // Converter data in
   input  wire logic        conv_valid_i,
   input  wire logic [11:0] conv_data_i,
   // Arithmetic unit feed
   output logic             alu_valid_o,
   output logic [11:0]      alu_data_o,
   output logic             alu_injected_o,
   output logic [15:0]      cal_gain_o,
   output logic [15:0]      cal_offset_o,
   output logic             cal_bypass_o,
   output logic             coef_update_only_o,
   // Mode status
   output logic             alu_selftest_enable_o
);
   typedef struct packed {
      logic        valid;
      logic [11:0] data;
      logic        inj;
      logic        bypass;
      logic        cal_only;
      logic        en;
      logic [15:0] gain;
      logic [15:0] offset;
   } ati_state_t;

   ati_state_t s_q;                     // Registered feed
   ati_state_t s_d;                     // Next feed

   ati_cfg_if cfg ();                   // Argument set

   // Register file on the bus
   ati_regs u_regs (
      .mclk_i            (mclk_i),
      .rst_i             (rst_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .cfg               (cfg)
   );

   // Pick the argument for this sample parity and conversion
   function automatic logic [11:0] pick_arg(input logic odd,
                                            input logic second,
                                            input logic [11:0] a1a,
                                            input logic [11:0] a1b,
                                            input logic [11:0] a2a,
                                            input logic [11:0] a2b);
      logic [11:0] r;
      if (odd) r = second ? a1b : a1a;  // RULE7 RULE8
      else     r = second ? a2b : a2a;  // RULE9 RULE10
      return r;
   endfunction

   // Injection decision and data select
   always_comb begin
      logic is_cal;
      logic inj;
      logic odd_eff;
      s_d    = s_q;
      is_cal = (scan_type_select_i == ati_pkg::SCAN_CALIBRATE) &
               ~balance_scan_i;
      // Calibration and balancing scans ignore the enable
      inj = cfg.enable & ~is_cal & ~balance_scan_i;  // RULE5 RULE6
      // Single acquisition has only odd samples
      odd_eff = sample_odd_i |
                (oversample_ratio_i == ati_pkg::OVS_SINGLE);  // RULE12
      s_d.en       = cfg.enable;
      s_d.valid    = conv_valid_i;       // RULE3
      s_d.inj      = inj & conv_valid_i;
      s_d.bypass   = inj;                // RULE4
      // Registered so the coefficient outputs come straight from flops
      s_d.gain     = inj ? ati_pkg::GAIN_UNITY : 16'h0000;  // RULE4
      s_d.offset   = ati_pkg::OFFSET_ZERO;                  // RULE4
      s_d.cal_only = is_cal;             // RULE11
      if (conv_valid_i) begin
         s_d.data = inj ? pick_arg(odd_eff, conv_second_i,
                                   cfg.arg_odd_first, cfg.arg_odd_second,
                                   cfg.arg_even_first, cfg.arg_even_second)
                        : conv_data_i;   // RULE2
      end
   end

   // Register the feed
   always_ff @(posedge mclk_i) begin
      if (rst_i) s_q <= '0;
      else       s_q <= s_d;
   end

   // Outputs straight from flops
   assign alu_valid_o           = s_q.valid;
   assign alu_data_o            = s_q.data;
   assign alu_injected_o        = s_q.inj;
   assign cal_bypass_o          = s_q.bypass;
   assign coef_update_only_o    = s_q.cal_only;
   assign alu_selftest_enable_o = s_q.en;
   // Fixed coefficients while bypassed; zero gain otherwise so the
   // engine keeps its own stored values
   assign cal_gain_o   = s_q.gain;                           // RULE4
   assign cal_offset_o = s_q.offset;                         // RULE4
endmodule

// ---- sim/ati_injector_assertions.sv ----
`timescale 1ns/10ps
// Port checks of the injector, one clock domain
module ati_injector_assertions (
   input wire logic        mclk_i, rst_i, avs_read_i, avs_write_i,
   input wire logic [9:0]  avs_address_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i, avs_readdata_o,
   input wire logic        avs_waitrequest_o, balance_scan_i, sample_odd_i,
   input wire logic [2:0]  scan_type_select_i, oversample_ratio_i,
   input wire logic        conv_second_i, conv_valid_i, alu_valid_o,
   input wire logic [11:0] conv_data_i, alu_data_o,
   input wire logic        alu_injected_o, cal_bypass_o, coef_update_only_o,
   input wire logic [15:0] cal_gain_o, cal_offset_o,
   input wire logic        alu_selftest_enable_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Fixed single wait state, answer low for one cycle only
   req_answer_a: assert property ((avs_read_i || avs_write_i)
      && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
   wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer too long");
   // Every conversion reaches the arithmetic unit one cycle later
   valid_delay_a: assert property (!$past(rst_i) |->
      alu_valid_o == $past(conv_valid_i)) else $error("valid delay wrong");
   real_data_a: assert property (alu_valid_o && !alu_injected_o |->
      alu_data_o == $past(conv_data_i)) else $error("real data lost");
   inj_pulse_a: assert property (alu_injected_o |-> alu_valid_o)
      else $error("injected without valid");
   // Calibration and balancing scans must never see test data
   cal_real_a: assert property (conv_valid_i &&
      scan_type_select_i == ati_pkg::SCAN_CALIBRATE && !balance_scan_i
      |=> !alu_injected_o) else $error("calibration injected");
   bal_real_a: assert property (conv_valid_i && balance_scan_i
      |=> !alu_injected_o) else $error("balancing injected");
   unity_gain_a: assert property (cal_offset_o == ati_pkg::OFFSET_ZERO &&
      cal_gain_o == (cal_bypass_o ? ati_pkg::GAIN_UNITY : 16'h0000))
      else $error("correction not bypassed");
   coef_only_a: assert property (!$past(rst_i) |-> coef_update_only_o ==
      $past(scan_type_select_i == 3'h3 && !balance_scan_i))
      else $error("coefficient flag wrong");
   cover property (alu_injected_o);
   cover property (conv_valid_i && balance_scan_i);
   cover property (!avs_waitrequest_o && avs_write_i);
endmodule

bind ati_injector ati_injector_assertions u_chk (.*);

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
// Self-checking bench: random arguments and scan contexts
module testbench;
   logic        mclk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [9:0]  avs_address_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd, w, rng_q;
   logic [2:0]  scan_type_select_i, oversample_ratio_i;
   logic        balance_scan_i, sample_odd_i, conv_second_i, conv_valid_i;
   logic        alu_valid_o, alu_injected_o, cal_bypass_o, coef_update_only_o;
   logic        alu_selftest_enable_o, en, inj, bal;
   logic [11:0] conv_data_i, alu_data_o;
   logic [15:0] cal_gain_o, cal_offset_o;
   logic [15:0] arg [4];
   int          failures, cmp_count;
   ati_injector DUT (.*);
   // Xorshift source, repeatable from its fixed seed
   function logic [31:0] rnd();
      rng_q ^= rng_q << 13;
      rng_q ^= rng_q >> 17;
      rng_q ^= rng_q << 5;
      return rng_q;
   endfunction
   // Readable bits: enable plus argument on the first, argument elsewhere
   function logic [15:0] mask(int i);
      return (i == 0) ? 16'h8FFF : 16'h0FFF;
   endfunction
   function logic [9:0] addr(int i);
      return {ati_pkg::IDX_ODD_FIRST + 8'(i), 2'b00};
   endfunction
   task chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done();
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      avs_read_i <= !wr;
      avs_write_i <= wr;
      avs_address_i <= a;
      avs_writedata_i <= d;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 20);
      chk("waitrequest", avs_waitrequest_o, 0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   // One conversion in a random context; expectation from the field rules
   task conv(input logic [31:0] r);
      int idx;
      @(posedge mclk_i);
      {conv_data_i, conv_second_i, sample_odd_i} <= r[21:8];
      {oversample_ratio_i, scan_type_select_i} <= r[5:0];
      balance_scan_i <= r[6] & r[7];
      conv_valid_i <= 1'b1;
      @(posedge mclk_i);
      conv_valid_i <= 1'b0;
      #1;
      bal = r[6] & r[7];
      inj = en && !bal && r[2:0] != ati_pkg::SCAN_CALIBRATE;
      idx = ((r[5:3] != ati_pkg::OVS_SINGLE && !r[8]) ? 2 : 0) + int'(r[9]);
      chk("valid", alu_valid_o, 1);
      chk("data", alu_data_o, inj ? arg[idx][11:0] : r[21:10]);
      chk("injected", alu_injected_o, inj);
      chk("gain", cal_gain_o, inj ? ati_pkg::GAIN_UNITY : 16'h0);
      chk("bypass", cal_bypass_o, inj);
      chk("offset", cal_offset_o, 0);
      chk("coef", coef_update_only_o, r[2:0] == 3'h3 && !bal);
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      test_done();
   end
   initial begin
      {rst_i, avs_read_i, avs_write_i, avs_address_i} = 13'h1000;
      {avs_writedata_i, scan_type_select_i, oversample_ratio_i} = 38'h0;
      {balance_scan_i, sample_odd_i, conv_second_i, conv_valid_i} = 4'h0;
      conv_data_i = 12'h000;
      avs_byteenable_i = 4'h3;
      rng_q = 32'h0000_003C;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(0, addr(i), 0);
         chk("reset value", rd, 0);
      end
      chk("enable reset", alu_selftest_enable_o, 0);
      bus(1, 10'h1AC, 32'hFFFF);
      bus(0, 10'h1AC, 0);
      chk("unmapped", rd, 0);
      for (int n = 0; n < 40; n++) begin
         for (int i = 0; i < 4; i++) begin
            w = (n == 0) ? 32'hFFFF_FFFF : rnd();
            bus(1, addr(i), w);
            arg[i] = w[15:0] & mask(i);
            bus(0, addr(i), 0);
            chk("readback", rd, arg[i]);
         end
         en = arg[0][ati_pkg::ENABLE_BIT];
         chk("enable", alu_selftest_enable_o, en);
         repeat (4) conv(rnd());
      end
      // Mid-run reset returns every argument and the enable to zero
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(0, addr(i), 0);
         chk("mid reset", rd, 0);
      end
      chk("enable mid reset", alu_selftest_enable_o, 0);
      // Low lane only: the upper nibble keeps its cleared value
      avs_byteenable_i <= 4'h1;
      bus(1, addr(1), 32'h0000_0ABC);
      avs_byteenable_i <= 4'h3;
      bus(0, addr(1), 0);
      chk("lane write", rd, 32'h0000_00BC);
      test_done();
   end
endmodule
